// ### rtl/efsp_sequencer.sv
// self-programming sequencer for data eeprom and boot-upgrade flash
// Summary of operation
// - eeprom is last 1 KB of array
// - two 512-byte blocks, erase clears block
// - high bit1 picks block, bit0 extends address
// - erase lasts 20 ms plus setting, else 30
// - byte program always lasts 62 us
// - command 0x96 erases addressed page
// - command 0x69 programs data byte at address
// - eeprom operation idles cpu until done
// - flash operation stops system clock until done
// - five-byte key enters boot-upgrade mode
// - five-byte key leaves boot-upgrade mode
// - full write protection refuses mode entry
// - upgrade flag shows boot-upgrade mode
// - upgrade address spans 0x0000 to 0x79ff
// - upgrade erase clears one 512-byte page
// - protected pages never erased or programmed
// - vector offset held in two byte registers
// - command at 0x2065, erase time 0x2066
`timescale 1ns/1ps
`default_nettype none
module efsp_sequencer
  import efsp_pkg::*;
#(
  parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // extended register bus
  input  wire logic [15:0] busAddr,
  input  wire logic [7:0]  busWrData,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  output logic      [7:0]  busRdData,
  // write protection configuration
  input  wire logic [5:0]  wpPageCfg,
  // nonvolatile array
  output logic             nvmErase,
  output logic             nvmProgram,
  output logic      [14:0] nvmAddr,
  output logic      [7:0]  nvmData,
  // core control
  output logic             cpuIdle,
  output logic             sysClkStop,
  output logic      [15:0] vectorOffset,
  output logic             bootUpgradeFlag
);

  efsp_state_t state;
  efsp_state_t next_state;
  logic [7:0]  progHigh, progLow, progData, progCmd;
  logic [4:0]  eraseTime;
  logic [7:0]  next_progHigh, next_progLow, next_progData, next_progCmd;
  logic [4:0]  next_eraseTime;
  logic [15:0] next_vectorOffset;
  logic [7:0]  next_busRdData;
  logic        next_bootUpgradeFlag;
  logic [14:0] next_nvmAddr;
  logic [7:0]  next_nvmData;
  logic        opBoot, next_opBoot;
  logic        cmdWrite;
  logic        enterMatch, exitMatch;
  logic        fullProtect, pageProtect;
  logic [14:0] eepromAddr, flashAddr;
  logic        addrAllowed;
  logic        startErase, startProgram;
  logic [31:0] eraseMs, eraseCycles, timerLoad;
  logic        opDone;

  assign cmdWrite = busWrite && (busAddr == ADDR_PROG_CMD);

  // unlock sequence detectors
  efsp_key_detect #(.KEY(KEY_ENTER)) u_enter (
    .clk(clk), .reset(reset), .cmdWrite(cmdWrite), .cmdByte(busWrData),
    .matched(enterMatch)
  );

  efsp_key_detect #(.KEY(KEY_EXIT)) u_exit (
    .clk(clk), .reset(reset), .cmdWrite(cmdWrite), .cmdByte(busWrData),
    .matched(exitMatch)
  );

  // address forming and protection checks
  always_comb begin
    eepromAddr = (progHigh[1] ? EEPROM_BLOCK1_BASE : EEPROM_BLOCK0_BASE)
                 | {6'h00, progHigh[0], progLow};
    flashAddr  = {progHigh[6:0], progLow};
    fullProtect = (wpPageCfg >= FLASH_PAGE_COUNT);
    pageProtect = (flashAddr[14:9] < wpPageCfg);
    addrAllowed = !bootUpgradeFlag
                  || (!pageProtect && flashAddr <= FLASH_LAST_ADDR);
  end

  // erase length from the setting, byte program fixed
  always_comb begin
    if (eraseTime <= ERASE_MAX_SETTING) begin
      eraseMs = 32'(ERASE_BASE_MS) + 32'(eraseTime);
    end else begin
      eraseMs = 32'(ERASE_DEFAULT_MS);
    end
    eraseCycles = eraseMs * 32'(CYCLES_PER_MS_P);
    timerLoad   = startErase ? eraseCycles : 32'(PROG_CYCLES);
  end

  // command decode, only while idle
  always_comb begin
    startErase   = cmdWrite && (state == ST_IDLE) && addrAllowed
                   && (busWrData == CMD_ERASE);
    startProgram = cmdWrite && (state == ST_IDLE) && addrAllowed
                   && (busWrData == CMD_PROGRAM);
  end

  efsp_op_timer #(.WIDTH(32)) u_timer (
    .clk(clk), .reset(reset), .start(startErase || startProgram),
    .loadCount(timerLoad), .done(opDone)
  );

  // operation state, array address and data
  always_comb begin
    next_state   = state;
    next_nvmAddr = nvmAddr;
    next_nvmData = nvmData;
    next_opBoot  = opBoot;
    unique case (state)
      ST_IDLE: begin
        if (startErase || startProgram) begin
          next_opBoot = bootUpgradeFlag;
          next_nvmData = progData;
          if (bootUpgradeFlag) begin
            next_nvmAddr = flashAddr;
          end else begin
            next_nvmAddr = eepromAddr;
          end
          if (startErase) begin
            next_state = ST_ERASE;
            next_nvmAddr[8:0] = 9'h000;
          end else begin
            next_state = ST_PROGRAM;
          end
        end
      end
      ST_ERASE, ST_PROGRAM: begin
        if (opDone) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // boot-upgrade mode flag
  always_comb begin
    next_bootUpgradeFlag = bootUpgradeFlag;
    if (exitMatch) begin
      next_bootUpgradeFlag = 1'b0;
    end else if (enterMatch && !fullProtect) begin
      next_bootUpgradeFlag = 1'b1;
    end
  end

  // register writes
  always_comb begin
    next_progHigh     = progHigh;
    next_progLow      = progLow;
    next_progData     = progData;
    next_progCmd      = progCmd;
    next_eraseTime    = eraseTime;
    next_vectorOffset = vectorOffset;
    if (busWrite) begin
      unique case (busAddr)
        ADDR_VECTOR_LOW:  next_vectorOffset[7:0]  = busWrData;
        ADDR_VECTOR_HIGH: next_vectorOffset[15:8] = busWrData;
        ADDR_PROG_HIGH:   next_progHigh  = busWrData;
        ADDR_PROG_LOW:    next_progLow   = busWrData;
        ADDR_PROG_DATA:   next_progData  = busWrData;
        ADDR_PROG_CMD:    next_progCmd   = busWrData;
        ADDR_ERASE_TIME:  next_eraseTime = busWrData[4:0];
        default: ;
      endcase
    end
  end

  // read data, unmapped reads as zero
  always_comb begin
    next_busRdData = busRdData;
    if (busRead) begin
      unique case (busAddr)
        ADDR_VECTOR_LOW:  next_busRdData = vectorOffset[7:0];
        ADDR_VECTOR_HIGH: next_busRdData = vectorOffset[15:8];
        ADDR_PROG_HIGH:   next_busRdData = progHigh;
        ADDR_PROG_LOW:    next_busRdData = progLow;
        ADDR_PROG_DATA:   next_busRdData = progData;
        ADDR_PROG_CMD:    next_busRdData = progCmd;
        ADDR_ERASE_TIME:  next_busRdData = {3'h0, eraseTime};
        ADDR_BOOT_STATUS: begin
          next_busRdData = 8'h00;
          next_busRdData[STAT_BOOT_BIT] = bootUpgradeFlag;
          next_busRdData[STAT_BUSY_BIT] = (state != ST_IDLE);
        end
        default:          next_busRdData = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state           <= ST_IDLE;
      progHigh        <= RST_BYTE;
      progLow         <= RST_BYTE;
      progData        <= RST_BYTE;
      progCmd         <= RST_BYTE;
      eraseTime       <= RST_ERASE_TIME;
      vectorOffset    <= {RST_BYTE, RST_BYTE};
      busRdData       <= RST_BYTE;
      bootUpgradeFlag <= 1'b0;
      nvmAddr         <= 15'h0000;
      nvmData         <= RST_BYTE;
      opBoot          <= 1'b0;
      nvmErase        <= 1'b0;
      nvmProgram      <= 1'b0;
      cpuIdle         <= 1'b0;
      sysClkStop      <= 1'b0;
    end else begin
      state           <= next_state;
      progHigh        <= next_progHigh;
      progLow         <= next_progLow;
      progData        <= next_progData;
      progCmd         <= next_progCmd;
      eraseTime       <= next_eraseTime;
      vectorOffset    <= next_vectorOffset;
      busRdData       <= next_busRdData;
      bootUpgradeFlag <= next_bootUpgradeFlag;
      nvmAddr         <= next_nvmAddr;
      nvmData         <= next_nvmData;
      opBoot          <= next_opBoot;
      nvmErase        <= (next_state == ST_ERASE);
      nvmProgram      <= (next_state == ST_PROGRAM);
      cpuIdle    <= (next_state != ST_IDLE) && !next_opBoot;
      sysClkStop <= (next_state != ST_IDLE) && next_opBoot;
    end
  end

  // helper: length of the running operation and its expected length
  logic [31:0] opCycles, expectCycles;
  always_ff @(posedge clk) begin
    if (reset) begin
      opCycles     <= 32'h0;
      expectCycles <= 32'h0;
    end else begin
      opCycles <= (nvmErase || nvmProgram) ? opCycles + 32'h1 : 32'h0;
      if (startErase || startProgram) begin
        expectCycles <= timerLoad;
      end
    end
  end

  property p_program_time;
    @(posedge clk) disable iff (reset)
      $fell(nvmProgram) |-> opCycles == 32'(PROG_CYCLES);
  endproperty
  a_program_time: assert property (p_program_time)
    else $error("byte program length wrong");
  property p_erase_time;
    @(posedge clk) disable iff (reset)
      $fell(nvmErase) |-> opCycles == expectCycles;
  endproperty
  a_erase_time: assert property (p_erase_time)
    else $error("erase length wrong");
  property p_enter_mode;
    @(posedge clk) disable iff (reset)
      enterMatch && !exitMatch && !fullProtect |=> bootUpgradeFlag;
  endproperty
  a_enter_mode: assert property (p_enter_mode)
    else $error("entry key did not set upgrade flag");
  property p_refuse_entry;
    @(posedge clk) disable iff (reset)
      !bootUpgradeFlag && fullProtect |=> !bootUpgradeFlag;
  endproperty
  a_refuse_entry: assert property (p_refuse_entry)
    else $error("mode entered under full protection");
  property p_exit_mode;
    @(posedge clk) disable iff (reset)
      exitMatch |=> !bootUpgradeFlag;
  endproperty
  a_exit_mode: assert property (p_exit_mode)
    else $error("exit key did not clear upgrade flag");
  property p_cpu_idle;
    @(posedge clk) disable iff (reset)
      $rose(nvmErase || nvmProgram) && !opBoot |-> cpuIdle && !sysClkStop;
  endproperty
  a_cpu_idle: assert property (p_cpu_idle)
    else $error("cpu not idled for eeprom operation");
  property p_clk_stop;
    @(posedge clk) disable iff (reset)
      $rose(nvmErase || nvmProgram) && opBoot
        |-> sysClkStop ##1 (sysClkStop == (nvmErase || nvmProgram));
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("clock not stopped for flash operation");
  property p_eeprom_region;
    @(posedge clk) disable iff (reset)
      $rose(nvmErase || nvmProgram) && !opBoot |-> nvmAddr[14:10] == 5'h1f;
  endproperty
  a_eeprom_region: assert property (p_eeprom_region)
    else $error("eeprom operation outside last kilobyte");
  property p_other_cmd;
    @(posedge clk) disable iff (reset)
      cmdWrite && state == ST_IDLE && busWrData != CMD_ERASE
        && busWrData != CMD_PROGRAM |=> state == ST_IDLE;
  endproperty
  a_other_cmd: assert property (p_other_cmd)
    else $error("unknown command started an operation");
  property p_protected;
    @(posedge clk) disable iff (reset)
      cmdWrite && bootUpgradeFlag && pageProtect |=> !$rose(nvmErase)
        && !$rose(nvmProgram);
  endproperty
  a_protected: assert property (p_protected)
    else $error("protected flash page touched");

endmodule
`default_nettype wire

// ### rtl/efsp_pkg.sv
// package: register map, command codes and timing constants of the sequencer
package efsp_pkg;

  // extended register space byte addresses
  localparam logic [15:0] ADDR_VECTOR_LOW  = 16'h2020;
  localparam logic [15:0] ADDR_VECTOR_HIGH = 16'h2021;
  localparam logic [15:0] ADDR_PROG_HIGH   = 16'h2062;
  localparam logic [15:0] ADDR_PROG_LOW    = 16'h2063;
  localparam logic [15:0] ADDR_PROG_DATA   = 16'h2064;
  localparam logic [15:0] ADDR_PROG_CMD    = 16'h2065;
  localparam logic [15:0] ADDR_ERASE_TIME  = 16'h2066;
  localparam logic [15:0] ADDR_BOOT_STATUS = 16'h2067;

  // values after reset
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [4:0] RST_ERASE_TIME = 5'h0a;

  // status register fields
  localparam int STAT_BOOT_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // command codes
  localparam logic [7:0] CMD_ERASE   = 8'h96;
  localparam logic [7:0] CMD_PROGRAM = 8'h69;
  localparam logic [39:0] KEY_ENTER  = 40'h12_34_56_78_9a;
  localparam logic [39:0] KEY_EXIT   = 40'hfe_dc_ba_98_76;

  // array map
  localparam logic [14:0] EEPROM_BLOCK0_BASE = 15'h7e00;
  localparam logic [14:0] EEPROM_BLOCK1_BASE = 15'h7c00;
  localparam logic [14:0] FLASH_LAST_ADDR    = 15'h79ff;
  localparam logic [5:0]  FLASH_PAGE_COUNT   = 6'h3d;

  // timing
  localparam int CLK_PERIOD_NS     = 25;
  localparam int NS_PER_MS         = 1000000;
  localparam int ERASE_BASE_MS     = 20;
  localparam int ERASE_DEFAULT_MS  = 30;
  localparam logic [4:0] ERASE_MAX_SETTING = 5'h14;
  localparam int PROG_TIME_NS      = 62000;
  localparam int CYCLES_PER_MS     = NS_PER_MS / CLK_PERIOD_NS;
  localparam int PROG_CYCLES       =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ERASE   = 2'b01,
    ST_PROGRAM = 2'b10
  } efsp_state_t;

endpackage

// ### rtl/efsp_op_timer.sv
// down-counter that times one nonvolatile operation
`timescale 1ns/1ps
`default_nettype none
module efsp_op_timer
  import efsp_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] loadCount,
  // status
  output logic                  done
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // load on start, then count down to zero
  always_comb begin
    next_count = count;
    if (start) begin
      next_count = loadCount;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == WIDTH'(1));  // last cycle of the operation

endmodule
`default_nettype wire

// ### rtl/efsp_key_detect.sv
// detector for one five-byte unlock sequence on the command register
`timescale 1ns/1ps
`default_nettype none
module efsp_key_detect
  import efsp_pkg::*;
#(
  parameter logic [39:0] KEY = 40'h0
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // command writes
  input  wire logic       cmdWrite,
  input  wire logic [7:0] cmdByte,
  // result
  output logic            matched
);

  logic [2:0] index;
  logic [2:0] next_index;
  logic       next_matched;
  logic [7:0] expected;

  // byte expected next, first byte sent first
  always_comb begin
    unique case (index)
      3'h0:    expected = KEY[39:32];
      3'h1:    expected = KEY[31:24];
      3'h2:    expected = KEY[23:16];
      3'h3:    expected = KEY[15:8];
      default: expected = KEY[7:0];
    endcase
  end

  // advance on match, restart on any other byte
  always_comb begin
    next_index   = index;
    next_matched = 1'b0;
    if (cmdWrite) begin
      if (cmdByte == expected) begin
        if (index == 3'h4) begin
          next_index   = 3'h0;
          next_matched = 1'b1;
        end else begin
          next_index = index + 3'h1;
        end
      end else if (cmdByte == KEY[39:32]) begin
        next_index = 3'h1;
      end else begin
        next_index = 3'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      index   <= 3'h0;
      matched <= 1'b0;
    end else begin
      index   <= next_index;
      matched <= next_matched;
    end
  end

endmodule
`default_nettype wire

// ### sim/efsp_nvm_model.sv
// behavioural nonvolatile array answering the sequencer's requests
`timescale 1ns/1ps
`default_nettype none
module efsp_nvm_model
  import efsp_pkg::*;
(
  // clock
  input  wire logic        clk,
  // array requests
  input  wire logic        nvmErase,
  input  wire logic        nvmProgram,
  input  wire logic [14:0] nvmAddr,
  input  wire logic [7:0]  nvmData,
  // count of bytes programmed twice without an erase between
  output int               progFault
);
  logic [7:0] mem [0:32767]; // eeprom is the top 1 KB of this array
  logic       used [0:32767];
  logic       eraseLast;
  logic       progLast;

  // blank array at start: every byte reads 0xff
  initial begin
    progFault = 0;
    eraseLast = 1'b0;
    progLast = 1'b0;
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hff;
      used[i] = 1'b0;
    end
  end

  // act once at the start of each request level
  always @(posedge clk) begin
    eraseLast <= nvmErase;
    progLast <= nvmProgram;
    if (nvmErase && !eraseLast) begin // whole 512-byte page
      for (int i = 0; i < 512; i++) begin
        mem[{nvmAddr[14:9], i[8:0]}] = 8'hff;
        used[{nvmAddr[14:9], i[8:0]}] = 1'b0;
      end
    end
    if (nvmProgram && !progLast) begin
      if (used[nvmAddr]) begin // second write needs an erase
        progFault++;
      end
      mem[nvmAddr] = mem[nvmAddr] & nvmData; // bits only fall
      used[nvmAddr] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### sim/eeprom_flash_self_programming_tb.sv
// self-checking bench for the self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
module eeprom_flash_self_programming_tb;
  import efsp_pkg::*;
  localparam int MS = 10;
  localparam int LIMIT = 20000;
  logic        clk;
  logic        reset;
  logic [15:0] busAddr;
  logic [7:0]  busWrData;
  logic        busWrite;
  logic        busRead;
  logic [7:0]  busRdData;
  logic [5:0]  wpPageCfg;
  logic        nvmErase;
  logic        nvmProgram;
  logic [14:0] nvmAddr;
  logic [7:0]  nvmData;
  logic        cpuIdle;
  logic        sysClkStop;
  logic [15:0] vectorOffset;
  logic        bootUpgradeFlag;
  int          progFault;
  int          n_errors;
  int          num_checks;
  int          cycles = 0;
  logic [7:0]  setTab [3] = '{8'h00, 8'h14, 8'h15};
  logic [7:0]  hiTab [3] = '{8'h02, 8'h01, 8'hfe};
  logic [14:0] baseTab [3] = '{15'h7c00, 15'h7e00, 15'h7c00};
  int          lenTab [3] = '{20 * MS, 40 * MS, 30 * MS};

  efsp_sequencer #(.CYCLES_PER_MS_P(MS)) u_dut (
    .clk(clk), .reset(reset), .busAddr(busAddr), .busWrData(busWrData),
    .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
    .wpPageCfg(wpPageCfg), .nvmErase(nvmErase), .nvmProgram(nvmProgram),
    .nvmAddr(nvmAddr), .nvmData(nvmData), .cpuIdle(cpuIdle),
    .sysClkStop(sysClkStop), .vectorOffset(vectorOffset),
    .bootUpgradeFlag(bootUpgradeFlag)
  );

  efsp_nvm_model u_nvm (
    .clk(clk), .nvmErase(nvmErase), .nvmProgram(nvmProgram),
    .nvmAddr(nvmAddr), .nvmData(nvmData), .progFault(progFault)
  );

  // clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    busAddr = a;
    busWrData = d;
    busWrite = 1'b1;
    @(negedge clk);
    busWrite = 1'b0;
  endtask

  // one-cycle read strobe, data compared the cycle after
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    busAddr = a;
    busRead = 1'b1;
    @(negedge clk);
    busRead = 1'b0;
    check(busRdData, exp);
  endtask

  // issue a command, then time the operation it starts (len 0: none)
  task automatic op(input logic [7:0] cmd, input logic [14:0] a,
                    input logic [7:0] d, input int len, input logic idle);
    int n;
    logic [1:0] kind;
    kind = (len == 0) ? 2'b00 : ((cmd == CMD_ERASE) ? 2'b10 : 2'b01);
    wr(ADDR_PROG_CMD, cmd);
    check({nvmErase, nvmProgram}, kind);
    if (len > 0) begin
      check(nvmAddr, a);
      check(cpuIdle, idle);
      check(sysClkStop, !idle);
      if (cmd == CMD_PROGRAM) begin
        check(nvmData, d);
      end
    end
    n = 0;
    // no bus access until the operation ends
    while ((nvmErase | nvmProgram) === 1'b1 && n < 5000) begin
      n++;
      @(negedge clk);
    end
    check(n[15:0], len[15:0]);
    check({cpuIdle, sysClkStop}, 2'b00);
  endtask

  // five command bytes, first byte first
  task automatic key(input logic [39:0] k);
    for (int i = 4; i >= 0; i--) begin
      wr(ADDR_PROG_CMD, k[i*8 +: 8]);
    end
    repeat (2) @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    reset = 1'b1;
    busAddr = 16'h0000;
    busWrData = 8'h00;
    busWrite = 1'b0;
    busRead = 1'b0;
    wpPageCfg = 6'h3d;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    // reset values, map and reserved bits
    rdchk(ADDR_ERASE_TIME, 8'h0a);
    rdchk(ADDR_VECTOR_LOW, 8'h00);
    rdchk(ADDR_BOOT_STATUS, 8'h00);
    rdchk(16'h2070, 8'h00);
    wr(ADDR_VECTOR_LOW, 8'h34);
    wr(ADDR_VECTOR_HIGH, 8'hc2);
    rdchk(ADDR_VECTOR_HIGH, 8'hc2);
    check(vectorOffset, 16'hc234);
    wr(ADDR_ERASE_TIME, 8'hff);
    rdchk(ADDR_ERASE_TIME, 8'h1f);
    $display("test registers done");
    // eeprom byte program, upper address bits ignored
    wr(ADDR_PROG_HIGH, 8'hff);
    wr(ADDR_PROG_LOW, 8'h55);
    wr(ADDR_PROG_DATA, 8'ha5);
    op(CMD_PROGRAM, 15'h7d55, 8'ha5, PROG_CYCLES, 1'b1);
    check(u_nvm.mem[15'h7d55], 8'ha5);
    rdchk(ADDR_PROG_DATA, 8'ha5);
    rdchk(ADDR_PROG_CMD, CMD_PROGRAM);
    $display("test eeprom program done");
    // block erase over the erase time settings
    wr(ADDR_PROG_LOW, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_ERASE_TIME, setTab[i]);
      wr(ADDR_PROG_HIGH, hiTab[i]);
      op(CMD_ERASE, baseTab[i], 8'h00, lenTab[i], 1'b1);
    end
    check(u_nvm.mem[15'h7d55], 8'hff);
    op(8'h55, 15'h0000, 8'h00, 0, 1'b0);
    $display("test eeprom erase done");
    // entry refused under full protection, then broken and full key
    key(KEY_ENTER);
    check(bootUpgradeFlag, 1'b0);
    wpPageCfg = 6'h02;
    wr(ADDR_PROG_CMD, 8'h12);
    wr(ADDR_PROG_CMD, 8'h34);
    key(KEY_ENTER);
    check(bootUpgradeFlag, 1'b1);
    rdchk(ADDR_BOOT_STATUS, 8'h01);
    $display("test upgrade entry done");
    // flash operations in upgrade mode
    wr(ADDR_PROG_HIGH, 8'h0a);
    op(CMD_ERASE, 15'h0a00, 8'h00, 30 * MS, 1'b0);
    wr(ADDR_PROG_HIGH, 8'h02);
    op(CMD_ERASE, 15'h0200, 8'h00, 0, 1'b0);
    wr(ADDR_PROG_HIGH, 8'h79);
    wr(ADDR_PROG_LOW, 8'hff);
    wr(ADDR_PROG_DATA, 8'h3c);
    op(CMD_PROGRAM, 15'h79ff, 8'h3c, PROG_CYCLES, 1'b0);
    check(u_nvm.mem[15'h79ff], 8'h3c);
    wr(ADDR_PROG_HIGH, 8'h7a);
    wr(ADDR_PROG_LOW, 8'h00);
    op(CMD_PROGRAM, 15'h7a00, 8'h3c, 0, 1'b0);
    // clear addresses after the batch
    wr(ADDR_PROG_HIGH, 8'h00);
    key(KEY_EXIT);
    check(bootUpgradeFlag, 1'b0);
    check(progFault[15:0], 16'h0000);
    $display("test upgrade mode done");
    wrap_up();
  end
endmodule
`default_nettype wire
